// ### include/tfr_pkg.sv
// Shared constants and carriers for the temperature fault response block.
// Assumes a 100 MHz system clock and a decoded PMBus command port.
package tfr_pkg;

  // ------------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------------
  localparam logic [7:0] CODE_HOT_FAULT_THR  = 8'h4F;
  localparam logic [7:0] CODE_HOT_ACTION     = 8'h50;
  localparam logic [7:0] CODE_HOT_WARN_THR   = 8'h51;
  localparam logic [7:0] CODE_COLD_WARN_THR  = 8'h52;
  localparam logic [7:0] CODE_COLD_FAULT_THR = 8'h53;
  localparam logic [7:0] CODE_COLD_ACTION    = 8'h54;

  // ------------------------------------------------------------------
  // Action byte fields
  // ------------------------------------------------------------------
  localparam int MODE_HI  = 7;
  localparam int MODE_LO  = 6;
  localparam int TRIES_HI = 5;
  localparam int TRIES_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] MODE_OFF_RETRY  = 2'h2;
  localparam logic [2:0] TRIES_NONE      = 3'h0;
  localparam logic [2:0] TRIES_ENDLESS   = 3'h7;

  // ------------------------------------------------------------------
  // Reset values (linear format, exponent zero for thresholds)
  // ------------------------------------------------------------------
  localparam logic [7:0]  RST_HOT_ACTION     = 8'h80;
  localparam logic [7:0]  RST_COLD_ACTION    = 8'h80;
  localparam logic [15:0] RST_HOT_FAULT_THR  = 16'h007D;
  localparam logic [15:0] RST_HOT_WARN_THR   = 16'h006E;
  localparam logic [15:0] RST_COLD_WARN_THR  = 16'h07DD;
  localparam logic [15:0] RST_COLD_FAULT_THR = 16'h07D8;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int RETRY_STEP_MS   = 35;
  localparam int RETRY_STEP_CYC  = RETRY_STEP_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] wdata;
  } tfr_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } tfr_temp_t;

  typedef struct packed {
    logic hot_fault;
    logic cold_fault;
    logic hot_warn;
    logic cold_warn;
  } tfr_flags_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_DELAY = 3'b010,
    ST_LATCH = 3'b100
  } tfr_state_t;

endpackage : tfr_pkg

// ### src/tfr_regs.sv
// Temperature limits, fault actions and the shutdown and retry sequencer.
// Assumes a decoded PMBus command port and temperature samples on sys_clk;
// the alert pin is open drain and resolved outside.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Every temperature fault pulls the alert low and sets its fault flag.
// R2 - Disable-and-retry code turns output off at once, then follows retries.
// R3 - Bits 5:3 give how many restarts follow a fault shutdown.
// R4 - Retry count zero: no restart, output stays off until fault cleared.
// R5 - Retry count seven: retry endlessly until disabled or other shutdown.
// R6 - Wait between restarts is (bits 2:0 plus one) times 35 ms.
// R7 - Retry delay runs 35 ms to 280 ms in 35 ms steps.
// R8 - Over-temperature faults use the action byte at code 0x50.
// R9 - Under-temperature faults use the action byte at code 0x54.
// R10 - Action registers are accessed as single bytes only.
// R11 - Limit registers are accessed as 16-bit words only.
// R12 - Over-temperature warning limit is a linear word at code 0x51.
// R13 - Under-temperature warning limit is a linear word at code 0x52.
// R14 - Under-temperature fault limit at 0x53 detects cold faults.
// R15 - Over-temperature fault limit at 0x4F detects hot faults.
// R16 - Other action codes leave output on but still flag and alert.
// R17 - Warning crossings set a warning flag and alert, output stays on.
module tfr_regs #(
  parameter int STEP_CYCLES = tfr_pkg::RETRY_STEP_CYC
) (
  // Clock, reset and enable
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Decoded command port
  input  wire tfr_pkg::tfr_cmd_t  cmd_in,
  output logic [15:0]             rsp_data,
  output logic                    rsp_ack,
  output logic                    rsp_nack,
  // Temperature samples and control
  input  wire tfr_pkg::tfr_temp_t temp_in,
  input  wire logic               run_request,
  input  wire logic               other_shutdown,
  input  wire logic               fault_clear,
  // Results
  output logic                    power_enable,
  output tfr_pkg::tfr_flags_t     flags,
  output tfr_pkg::tfr_state_t     seq_state,
  // Open-drain alert pin
  input  wire logic               host_alert_line_i,
  output logic                    host_alert_line_o,
  output logic                    host_alert_line_oe_n,
  output logic                    alert_line_low
);
  import tfr_pkg::*;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [7:0]  hot_fault_action;
  logic [7:0]  cold_fault_action;
  logic [15:0] hot_fault_threshold;
  logic [15:0] hot_warning_threshold;
  logic [15:0] cold_warning_threshold;
  logic [15:0] cold_fault_threshold;

  logic        cmd_ok;
  logic        cmd_byte_reg;
  logic [15:0] cmd_rdata;

  logic        hot_trip;
  logic        cold_trip;
  logic        hot_warn_hit;
  logic        cold_warn_hit;
  logic        trip;
  logic [7:0]  trip_action;
  logic [2:0]  trip_tries;

  logic [7:0]  act;
  logic [2:0]  tries_used;
  logic [31:0] step_cnt;
  logic [2:0]  steps_left;
  logic        sync_a;
  logic        sync_b;

  // ------------------------------------------------------------------
  // Linear format to fixed point
  // ------------------------------------------------------------------

  // Scales mantissa by two to the exponent, with 16 fraction bits.
  function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
    logic signed [47:0] m;
    logic [5:0]         sh;
    m  = 48'(signed'(v[10:0]));
    sh = {1'b0, ~v[15], v[14:11]};
    return m <<< sh;
  endfunction : lin_fix

  // ------------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------------

  // Finds the register, its access size and its read value.
  always_comb begin
    cmd_ok       = 1'b1;
    cmd_byte_reg = 1'b0;
    cmd_rdata    = 16'h0000;
    if (cmd_in.code == CODE_HOT_FAULT_THR) begin
      cmd_rdata = hot_fault_threshold;
    end else if (cmd_in.code == CODE_HOT_ACTION) begin
      cmd_byte_reg = 1'b1;
      cmd_rdata    = {8'h00, hot_fault_action};
    end else if (cmd_in.code == CODE_HOT_WARN_THR) begin
      cmd_rdata = hot_warning_threshold;
    end else if (cmd_in.code == CODE_COLD_WARN_THR) begin
      cmd_rdata = cold_warning_threshold;
    end else if (cmd_in.code == CODE_COLD_FAULT_THR) begin
      cmd_rdata = cold_fault_threshold;
    end else if (cmd_in.code == CODE_COLD_ACTION) begin
      cmd_byte_reg = 1'b1;
      cmd_rdata    = {8'h00, cold_fault_action};
    end else begin
      cmd_ok = 1'b0;
    end
    // Size must match: bytes for actions, words for limits.
    if (cmd_in.word == cmd_byte_reg) begin // R10 R11
      cmd_ok = 1'b0;
    end
  end

  // Stores writes that pass decode.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hot_fault_action       <= RST_HOT_ACTION;
      cold_fault_action      <= RST_COLD_ACTION;
      hot_fault_threshold    <= RST_HOT_FAULT_THR;
      hot_warning_threshold  <= RST_HOT_WARN_THR;
      cold_warning_threshold <= RST_COLD_WARN_THR;
      cold_fault_threshold   <= RST_COLD_FAULT_THR;
    end else if (ce && cmd_in.valid && cmd_in.write && cmd_ok) begin
      if (cmd_in.code == CODE_HOT_FAULT_THR) begin
        hot_fault_threshold <= cmd_in.wdata; // R15
      end else if (cmd_in.code == CODE_HOT_ACTION) begin
        hot_fault_action <= cmd_in.wdata[7:0]; // R8 R10
      end else if (cmd_in.code == CODE_HOT_WARN_THR) begin
        hot_warning_threshold <= cmd_in.wdata; // R12
      end else if (cmd_in.code == CODE_COLD_WARN_THR) begin
        cold_warning_threshold <= cmd_in.wdata; // R13
      end else if (cmd_in.code == CODE_COLD_FAULT_THR) begin
        cold_fault_threshold <= cmd_in.wdata; // R14
      end else begin
        cold_fault_action <= cmd_in.wdata[7:0]; // R9 R10
      end
    end
  end

  // Answers each command one cycle later with ack or nack.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_data <= 16'h0000;
      rsp_ack  <= 1'b0;
      rsp_nack <= 1'b0;
    end else if (ce) begin
      rsp_ack  <= cmd_in.valid && cmd_ok;
      rsp_nack <= cmd_in.valid && !cmd_ok;
      if (cmd_in.valid && cmd_ok && !cmd_in.write) begin
        rsp_data <= cmd_rdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Limit comparison
  // ------------------------------------------------------------------

  // Compares each sample against the four limits.
  always_comb begin
    hot_trip      = temp_in.valid &&
                    lin_fix(temp_in.value) >=
                    lin_fix(hot_fault_threshold); // R15
    cold_trip     = temp_in.valid &&
                    lin_fix(temp_in.value) <=
                    lin_fix(cold_fault_threshold); // R14
    hot_warn_hit  = temp_in.valid &&
                    lin_fix(temp_in.value) >=
                    lin_fix(hot_warning_threshold); // R12 R17
    cold_warn_hit = temp_in.valid &&
                    lin_fix(temp_in.value) <=
                    lin_fix(cold_warning_threshold); // R13 R17
  end

  // Picks the action byte that belongs to the fault seen; hot first.
  assign trip        = hot_trip || cold_trip;
  assign trip_action = hot_trip ? hot_fault_action   // R8
                                : cold_fault_action; // R9
  assign trip_tries  = trip_action[TRIES_HI:TRIES_LO];

  // ------------------------------------------------------------------
  // Sticky flags and alert
  // ------------------------------------------------------------------

  // Flags set by events; a set in the clearing cycle wins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags <= '0;
    end else if (ce) begin
      flags.hot_fault  <= (flags.hot_fault && !fault_clear) ||
                          hot_trip; // R1
      flags.cold_fault <= (flags.cold_fault && !fault_clear) ||
                          cold_trip; // R1
      flags.hot_warn   <= (flags.hot_warn && !fault_clear) ||
                          hot_warn_hit; // R17
      flags.cold_warn  <= (flags.cold_warn && !fault_clear) ||
                          cold_warn_hit; // R17
    end
  end

  // Pulls the line low while any flag stands.
  assign host_alert_line_o    = 1'b0;
  assign host_alert_line_oe_n = ~(|flags); // R1 R16 R17

  // Brings the resolved line level into the clock domain.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else if (ce) begin
      sync_a <= host_alert_line_i;
      sync_b <= sync_a;
    end
  end

  assign alert_line_low = ~sync_b;

  // ------------------------------------------------------------------
  // Shutdown and retry sequencer
  // ------------------------------------------------------------------

  // Runs, waits out retry steps, or holds the output off.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_state    <= ST_RUN;
      power_enable <= 1'b0;
      act          <= 8'h00;
      tries_used   <= 3'h0;
      step_cnt     <= 32'h0000_0000;
      steps_left   <= 3'h0;
    end else if (ce) begin
      case (seq_state)
        ST_RUN: begin
          power_enable <= run_request;
          if (!run_request || fault_clear) begin
            tries_used <= 3'h0;
          end
          if (trip && trip_action[MODE_HI:MODE_LO] == MODE_OFF_RETRY) begin
            power_enable <= 1'b0; // R2
            act          <= trip_action;
            if (trip_tries == TRIES_NONE) begin
              seq_state <= ST_LATCH; // R4
            end else if (trip_tries != TRIES_ENDLESS &&
                         tries_used >= trip_tries) begin
              seq_state <= ST_LATCH; // R3
            end else begin
              seq_state  <= ST_DELAY; // R3 R5
              step_cnt   <= 32'h0000_0000;
              steps_left <= trip_action[DELAY_HI:DELAY_LO]; // R6
              if (trip_tries != TRIES_ENDLESS) begin
                tries_used <= tries_used + 3'h1; // R3
              end
            end
          end
          // Other action codes keep running; flags still raise alert.
          // R16
        end
        ST_DELAY: begin
          power_enable <= 1'b0;
          if (!run_request) begin
            seq_state  <= ST_RUN; // R5
            tries_used <= 3'h0;
          end else if (other_shutdown) begin
            seq_state <= ST_LATCH; // R5
          end else if (step_cnt == 32'(STEP_CYCLES - 1)) begin
            step_cnt <= 32'h0000_0000; // R7
            if (steps_left == 3'h0) begin
              seq_state    <= ST_RUN; // R6
              power_enable <= 1'b1;
            end else begin
              steps_left <= steps_left - 3'h1; // R6 R7
            end
          end else begin
            step_cnt <= step_cnt + 32'h0000_0001;
          end
        end
        ST_LATCH: begin
          power_enable <= 1'b0; // R4
          if (fault_clear) begin
            seq_state  <= ST_RUN; // R4
            tries_used <= 3'h0;
          end
        end
        default: begin
          seq_state    <= ST_LATCH;
          power_enable <= 1'b0;
        end
      endcase
    end
  end

endmodule : tfr_regs

// ### sim/tfr_chk.sv
// Concurrent checks on the ports of the temperature fault response block.
// Assumes it is bound into tfr_regs and sees nothing but its ports.
`timescale 1ns/1ps
module tfr_chk
  import tfr_pkg::*;
#(
  parameter int STEP_CYCLES = 8
) (
  // Clock and control
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       run_request,
  input wire logic       other_shutdown,
  input wire logic       fault_clear,
  // Command port and samples
  input wire tfr_cmd_t   cmd_in,
  input wire logic [15:0] rsp_data,
  input wire logic       rsp_ack,
  input wire logic       rsp_nack,
  input wire tfr_temp_t  temp_in,
  // Results and alert pin
  input wire logic       power_enable,
  input wire tfr_flags_t flags,
  input wire tfr_state_t seq_state,
  input wire logic       host_alert_line_i,
  input wire logic       host_alert_line_o,
  input wire logic       host_alert_line_oe_n,
  input wire logic       alert_line_low
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Size class of the addressed register; neither means unknown code.
  logic is_word;
  logic is_byte;
  int   dly_cnt;
  assign is_word = cmd_in.code inside {CODE_HOT_FAULT_THR, CODE_HOT_WARN_THR,
    CODE_COLD_WARN_THR, CODE_COLD_FAULT_THR};
  assign is_byte = cmd_in.code inside {CODE_HOT_ACTION, CODE_COLD_ACTION};

  // Counts cycles spent waiting between restarts.
  always_ff @(posedge sys_clk) begin
    if (rst || seq_state != ST_DELAY) dly_cnt <= 0;
    else if (ce) dly_cnt <= dly_cnt + 1;
  end

  a_size_taken: assert property (ce && cmd_in.valid
    && (is_word || is_byte) && is_word == cmd_in.word
    |=> rsp_ack && !rsp_nack) else $error("bad ack");
  a_size_refused: assert property (ce && cmd_in.valid
    && (is_word != cmd_in.word || !(is_word || is_byte))
    |=> rsp_nack && !rsp_ack) else $error("missing nack");
  a_alert_follows: assert property ((|flags) == !host_alert_line_oe_n)
    else $error("alert does not follow flags");
  a_flag_cause: assert property ($rose(flags.hot_fault)
    || $rose(flags.cold_fault) |-> $past(temp_in.valid))
    else $error("fault flag without sample");
  a_off_outside: assert property (seq_state != ST_RUN |-> !power_enable)
    else $error("output on while shut down");
  a_delay_span: assert property ($fell(seq_state == ST_DELAY)
    && seq_state == ST_RUN && $past(run_request)
    |-> dly_cnt >= STEP_CYCLES && dly_cnt <= 8 * STEP_CYCLES
    && dly_cnt % STEP_CYCLES == 0)
    else $error("retry wait out of range");
  a_delay_ends: assert property (seq_state == ST_DELAY
    |-> dly_cnt < 8 * STEP_CYCLES) else $error("retry wait hangs");
  a_restart_on: assert property (seq_state == ST_RUN && run_request
    && $past(seq_state) == ST_DELAY && $past(run_request) |-> power_enable)
    else $error("restart without output");
  a_latch_holds: assert property (seq_state == ST_LATCH && !fault_clear
    |=> seq_state == ST_LATCH) else $error("latch left without clear");
  a_clear_unlatch: assert property (seq_state == ST_LATCH && fault_clear
    && ce |=> seq_state == ST_RUN) else $error("clear did not unlatch");
  a_alert_synced: assert property ($rose(|flags) && ce ##1 ce
    |=> alert_line_low) else $error("alert pin not seen low");
  a_freeze_state: assert property (!ce
    |=> $stable(seq_state) && $stable(flags) && $stable(power_enable))
    else $error("state moved while disabled");
endmodule : tfr_chk

bind tfr_regs tfr_chk #(.STEP_CYCLES(STEP_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .run_request(run_request),
  .other_shutdown(other_shutdown), .fault_clear(fault_clear),
  .cmd_in(cmd_in), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
  .rsp_nack(rsp_nack), .temp_in(temp_in), .power_enable(power_enable),
  .flags(flags), .seq_state(seq_state),
  .host_alert_line_i(host_alert_line_i),
  .host_alert_line_o(host_alert_line_o),
  .host_alert_line_oe_n(host_alert_line_oe_n),
  .alert_line_low(alert_line_low));

// ### sim/tfr_host.sv
// Host model: issues byte and word transfers and pulls up the alert line.
// Assumes the decoded command port of tfr_regs with a one-cycle request.
`timescale 1ns/1ps
module tfr_host
  import tfr_pkg::*;
(
  // Clock and answers
  input  wire logic        sys_clk,
  input  wire logic        rsp_ack,
  input  wire logic        rsp_nack,
  input  wire logic [15:0] rsp_data,
  input  wire logic        host_alert_line_oe_n,
  // Requests and resolved pin
  output tfr_cmd_t         cmd_in,
  output logic             host_alert_line_i
);
  // The pull-up wins unless the device pulls the line low.
  assign host_alert_line_i = host_alert_line_oe_n ? 1'b1 : 1'b0;
  initial cmd_in = '0;

  // One request pulse, then a bounded wait for ack or nack.
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
                      input logic [15:0] d, output logic [1:0] resp,
                      output logic [15:0] rdata);
    int n;
    @(negedge sys_clk);
    cmd_in <= {1'b1, wr, wd, code, wd ? d : {8'h00, d[7:0]}};
    @(negedge sys_clk);
    cmd_in.valid <= 1'b0;
    resp = {rsp_ack, rsp_nack};
    for (n = 0; n < 3 && resp == 2'b00; n++) begin
      @(negedge sys_clk);
      resp = {rsp_ack, rsp_nack};
    end
    rdata = rsp_data;
  endtask : xfer
endmodule : tfr_host

// ### sim/tb.sv
// Testbench for tfr_regs: register access, warnings, trips and retries.
// Assumes tfr_host as the far side and a short retry step in simulation.
`timescale 1ns/1ps
module tb;
  import tfr_pkg::*;
  localparam int STEP = 8;
  logic        sys_clk, rst, ce, run_request, other_shutdown, fault_clear;
  tfr_cmd_t    cmd_in;
  tfr_temp_t   temp_in;
  tfr_flags_t  flags;
  tfr_state_t  seq_state;
  logic [15:0] rsp_data, rd;
  logic [1:0]  resp;
  logic        rsp_ack, rsp_nack, power_enable, al_i, al_o, al_oe_n, al_low;
  int          fail_count, samples_checked;

  tfr_regs #(.STEP_CYCLES(STEP)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .cmd_in(cmd_in),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_nack(rsp_nack),
    .temp_in(temp_in), .run_request(run_request),
    .other_shutdown(other_shutdown), .fault_clear(fault_clear),
    .power_enable(power_enable), .flags(flags), .seq_state(seq_state),
    .host_alert_line_i(al_i), .host_alert_line_o(al_o),
    .host_alert_line_oe_n(al_oe_n), .alert_line_low(al_low));
  tfr_host host_u (.sys_clk(sys_clk), .rsp_ack(rsp_ack), .rsp_nack(rsp_nack),
    .rsp_data(rsp_data), .host_alert_line_oe_n(al_oe_n), .cmd_in(cmd_in),
    .host_alert_line_i(al_i));

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Compares a cycle count exactly.
  task automatic chk_cnt(input string what, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_cnt
  // A read expected to be acked compares its data with d; a write sends d.
  task automatic acc(input logic w, input logic wd, input logic [7:0] code,
                     input logic [15:0] d, input logic [1:0] er);
    host_u.xfer(w, wd, code, d, resp, rd);
    chk("response", {14'h0, er}, {14'h0, resp});
    if (!w && er == 2'b10) chk("read data", d, rd);
  endtask : acc
  task automatic temp(input logic [15:0] v);
    @(negedge sys_clk);
    temp_in <= {1'b1, v};
    @(negedge sys_clk);
    temp_in.valid <= 1'b0;
  endtask : temp
  task automatic st(input tfr_state_t s, input logic p);
    chk("state", {13'h0, s}, {13'h0, seq_state});
    chk("power", {15'h0, p}, {15'h0, power_enable});
  endtask : st
  task automatic clear();
    @(negedge sys_clk);
    fault_clear <= 1'b1;
    @(negedge sys_clk);
    fault_clear <= 1'b0;
    @(negedge sys_clk);
    chk("flags", 16'h0, {12'h0, flags});
  endtask : clear
  task automatic wait_run(input int e);
    int n = 0;
    while (seq_state !== ST_RUN && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    chk_cnt("retry wait", e, n);
  endtask : wait_run
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Free-running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end

  // Main sequence of register accesses and temperature events.
  initial begin
    {rst, run_request, other_shutdown, fault_clear} = 4'b1000;
    ce = 1'b1;
    temp_in = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (8) @(negedge sys_clk);
    rst <= 1'b0;
    acc(1, 0, CODE_HOT_WARN_THR, 16'h0000, 2'b01);
    acc(1, 1, CODE_COLD_ACTION, 16'h0000, 2'b01);
    acc(0, 1, 8'h55, 16'h0000, 2'b01);
    acc(0, 0, CODE_HOT_ACTION, {8'h0, RST_HOT_ACTION}, 2'b10);
    acc(0, 0, CODE_COLD_ACTION, {8'h0, RST_COLD_ACTION}, 2'b10);
    acc(0, 1, CODE_HOT_WARN_THR, RST_HOT_WARN_THR, 2'b10);
    acc(1, 1, CODE_HOT_FAULT_THR, 16'h0064, 2'b10);
    acc(1, 1, CODE_HOT_WARN_THR, 16'h0050, 2'b10);
    acc(1, 1, CODE_COLD_WARN_THR, 16'h0010, 2'b10);
    acc(1, 1, CODE_COLD_FAULT_THR, 16'h0005, 2'b10);
    acc(0, 1, CODE_COLD_WARN_THR, 16'h0010, 2'b10);
    acc(0, 1, CODE_COLD_FAULT_THR, 16'h0005, 2'b10);
    run_request <= 1'b1;
    temp(16'h0050);
    st(ST_RUN, 1'b1);
    chk("flags", 16'h0002, {12'h0, flags});
    repeat (3) @(negedge sys_clk);
    chk("alert low", 16'h0001, {15'h0, al_low});
    chk("alert drive", 16'h0000, {15'h0, al_o});
    clear();
    acc(1, 0, CODE_HOT_ACTION, 16'h0000, 2'b10);
    temp(16'h0064);
    st(ST_RUN, 1'b1);
    chk("flags", 16'h000A, {12'h0, flags});
    clear();
    acc(1, 0, CODE_HOT_ACTION, 16'h0089, 2'b10);
    temp(16'h0064);
    st(ST_DELAY, 1'b0);
    wait_run(2 * STEP);
    st(ST_RUN, 1'b1);
    temp(16'h0064);
    st(ST_LATCH, 1'b0);
    clear();
    st(ST_RUN, 1'b1);
    temp(16'h0005);
    st(ST_LATCH, 1'b0);
    chk("flags", 16'h0005, {12'h0, flags});
    repeat (80) @(negedge sys_clk);
    st(ST_LATCH, 1'b0);
    clear();
    for (int k = 0; k < 4; k++) begin
      acc(1, 0, CODE_COLD_ACTION, {8'h0, 5'b10111, k[0] ? 3'h7 : 3'h0},
          2'b10);
      temp(16'h0005);
      st(ST_DELAY, 1'b0);
      wait_run(k[0] ? 8 * STEP : STEP);
    end
    temp(16'h0005);
    other_shutdown <= 1'b1;
    repeat (3) @(negedge sys_clk);
    st(ST_LATCH, 1'b0);
    other_shutdown <= 1'b0;
    clear();
    // Frozen clock enable must hold the wait; dropping the run ends it.
    temp(16'h0005);
    ce <= 1'b0;
    repeat (100) @(negedge sys_clk);
    st(ST_DELAY, 1'b0);
    ce <= 1'b1;
    run_request <= 1'b0;
    @(negedge sys_clk);
    st(ST_RUN, 1'b0);
    give_verdict();
  end
endmodule : tb
